// ### core/sptr_dist.sv
`default_nettype none
module sptr_dist #(
  parameter int LINES = 1,
  parameter int CPUS = 4,
  parameter bit EXT_PRESENT = 1'b1,
  parameter int EXT_SIZE = 0,
  parameter bit ARCH_31 = 1'b1,
  parameter logic [1023:0] FIXED_MASK = '0,
  parameter logic [7:0] FIXED_TGT = 8'h01
) (
  input wire logic sys_clk_in, // 250 MHz clock
  input wire logic rst_n_in, // Async reset, active low
  input wire sptr_pkg::sptr_req_type reg_req_in, // Register request
  output sptr_pkg::sptr_rsp_type reg_rsp_out, // Register answer
  input wire logic security_disable_in, // Single security state
  input wire logic route_secure_in, // Affinity routing, secure state
  input wire logic route_nonsecure_in, // Affinity routing, non-secure state
  input wire logic [32*(LINES+1)-1:0] irq_secure_in, // Group 0 or secure group 1
  input wire logic [32*(LINES+1)-1:0] ns_grant_in, // Non-secure access granted
  input wire logic [32*(EXT_SIZE+1)-1:0] ext_secure_in, // Extended id is secure
  input wire logic [32*LINES-1:0] spi_line_in, // Shared lines, pins
  input wire logic [CPUS*16-1:0] ppi_line_in, // Private lines, pins
  input wire logic [32*(EXT_SIZE+1)-1:0] ext_line_in, // Extended lines, pins
  input wire logic [CPUS*16-1:0] sgi_set_in, // Software interrupt set pulses
  input wire sptr_pkg::sptr_clr_type clr_in, // Acknowledge clears pending
  output logic [CPUS-1:0][32*(LINES+1)-1:0] cpu_pending_out, // Forwarded per processor
  output logic [32*(EXT_SIZE+1)-1:0] ext_pending_out // Extended pending state
);
  import sptr_pkg::*;

  localparam int NIRQ = 32 * (LINES + 1);
  localparam int NSPI = NIRQ - PRIV_COUNT;
  localparam int NEXT = 32 * (EXT_SIZE + 1);
  localparam bit EXT_ON = EXT_PRESENT && ARCH_31;
  localparam int SYNW = NSPI + CPUS * 16 + NEXT;

  function automatic logic are_of(input logic isec, input logic rs, input logic rn);
    are_of = isec ? rs : rn;
  endfunction

  function automatic logic ns_blocked(input logic sec, input logic isec, input logic grant,
                                      input logic are, input logic ds);
    ns_blocked = !sec && isec && !ds && (!grant || are);
  endfunction

  function automatic logic in_window(input logic [15:0] a, input logic [15:0] base,
                                     input int len);
    in_window = a >= base && 32'(a) < 32'(base) + 32'(len);
  endfunction

  function automatic logic wr_bit(input sptr_req_type r, input int b);
    wr_bit = r.write && r.be[b/8] && r.wdata[b];
  endfunction

  logic rst_meta_r;
  logic rst_sync_n_r;
  logic [SYNW-1:0] sync_q;
  logic [NSPI-1:0] spi_lvl;
  logic [CPUS-1:0][15:0] ppi_lvl;
  logic [NEXT-1:0] ext_lvl;

  logic [CPUS-1:0][31:0] bank_r;
  logic [CPUS-1:0][31:0] bank_nxt;
  logic [NSPI-1:0] spi_r;
  logic [NSPI-1:0] spi_nxt;
  logic [NEXT-1:0] ext_r;
  logic [NEXT-1:0] ext_nxt;
  logic [NSPI-1:0][CPUS-1:0] tgt_r;
  logic [NSPI-1:0][CPUS-1:0] tgt_nxt;
  sptr_rsp_type rsp_r;
  sptr_rsp_type rsp_nxt;
  logic [CPUS-1:0][NIRQ-1:0] fwd_r;
  logic [CPUS-1:0][NIRQ-1:0] fwd_nxt;

  logic [31:0] set_bank;
  logic [NSPI-1:0] set_spi;
  logic [NEXT-1:0] set_ext;
  logic cpu_ok;
  logic bank_ok;

  // Internal reset asserts at once and releases two edges after the pin
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  sptr_sync #(
    .WIDTH(SYNW)
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_sync_n_r),
    .d_in({ext_line_in, ppi_line_in, spi_line_in}),
    .q_out(sync_q)
  );

  assign spi_lvl = sync_q[NSPI-1:0];
  assign ppi_lvl = sync_q[NSPI +: CPUS*16];
  assign ext_lvl = sync_q[NSPI+CPUS*16 +: NEXT];

  // Banked views exist only for connected processors below eight
  assign cpu_ok = 32'(reg_req_in.cpu) < 32'(CPUS);
  assign bank_ok = cpu_ok && (32'(reg_req_in.cpu) < 32'(MAX_BANK_CPU));

  // Register access: read data, write-one-to-set masks, target updates
  always_comb begin
    logic [15:0] off;
    int n;
    int id;
    logic wb;
    logic isec;
    logic blk;
    logic are;
    off = '0;
    n = 0;
    id = 0;
    wb = 1'b0;
    isec = 1'b0;
    blk = 1'b0;
    are = 1'b0;
    rsp_nxt.ack = reg_req_in.valid;
    rsp_nxt.rdata = RDATA_RST;
    set_bank = '0;
    set_spi = '0;
    set_ext = '0;
    tgt_nxt = tgt_r;
    if (reg_req_in.valid) begin
      if (in_window(reg_req_in.addr, PEND_BASE, NIRQ / 8)) begin
        off = reg_req_in.addr - PEND_BASE;
        n = 32'(off[15:2]);
        for (int b = 0; b < BITS_PER_REG; b++) begin
          id = n * BITS_PER_REG + b;
          isec = irq_secure_in[id];
          are = are_of(isec, route_secure_in, route_nonsecure_in);
          blk = ns_blocked(reg_req_in.secure, isec, ns_grant_in[id], are,
                           security_disable_in);
          wb = wr_bit(reg_req_in, b);
          if (id < PRIV_COUNT) begin
            if (bank_ok && !are && !blk) begin
              rsp_nxt.rdata[b] = bank_r[reg_req_in.cpu[2:0]][id];
              if (id >= SGI_COUNT) begin
                set_bank[id] = wb;
              end
            end
          end else if (!blk) begin
            rsp_nxt.rdata[b] = spi_r[id-PRIV_COUNT];
            set_spi[id-PRIV_COUNT] = wb;
          end
        end
      end else if (EXT_ON && in_window(reg_req_in.addr, EXT_BASE, NEXT / 8)) begin
        off = reg_req_in.addr - EXT_BASE;
        n = 32'(off[15:2]);
        for (int b = 0; b < BITS_PER_REG; b++) begin
          id = n * BITS_PER_REG + b;
          isec = ext_secure_in[id];
          are = are_of(isec, route_secure_in, route_nonsecure_in);
          blk = !reg_req_in.secure && isec && !security_disable_in;
          wb = wr_bit(reg_req_in, b);
          if (are && !blk) begin
            rsp_nxt.rdata[b] = ext_r[id];
            set_ext[id] = wb;
          end
        end
      end else if (in_window(reg_req_in.addr, TGT_BASE, NIRQ)) begin
        off = reg_req_in.addr - TGT_BASE;
        n = 32'(off[15:2]);
        for (int k = 0; k < BYTES_PER_REG; k++) begin
          id = n * BYTES_PER_REG + k;
          isec = irq_secure_in[id];
          are = are_of(isec, route_secure_in, route_nonsecure_in);
          blk = ns_blocked(reg_req_in.secure, isec, ns_grant_in[id], 1'b0,
                           security_disable_in);
          if (CPUS > 1 && !are && !blk) begin
            if (id < PRIV_COUNT) begin
              if (bank_ok) begin
                rsp_nxt.rdata[8*k +: 8] = 8'(1 << reg_req_in.cpu[2:0]);
              end
            end else if (FIXED_MASK[id]) begin
              rsp_nxt.rdata[8*k +: CPUS] = FIXED_TGT[CPUS-1:0];
            end else begin
              rsp_nxt.rdata[8*k +: CPUS] = tgt_r[id-PRIV_COUNT];
              if (reg_req_in.write && reg_req_in.be[k]) begin
                tgt_nxt[id-PRIV_COUNT] = reg_req_in.wdata[8*k +: CPUS];
              end
            end
          end
        end
      end
      if (reg_req_in.write) begin
        rsp_nxt.rdata = RDATA_RST;
      end
    end
  end

  // Pending state: clear by acknowledge, then every set source wins
  always_comb begin
    int cid;
    cid = 32'(clr_in.id);
    bank_nxt = bank_r;
    spi_nxt = spi_r;
    ext_nxt = ext_r;
    if (clr_in.valid) begin
      if (cid >= EXT_ID_BASE) begin
        if (cid < EXT_ID_BASE + NEXT) begin
          ext_nxt[cid-EXT_ID_BASE] = 1'b0;
        end
      end else if (cid < PRIV_COUNT) begin
        for (int c = 0; c < CPUS; c++) begin
          if (32'(clr_in.cpu) == c) begin
            bank_nxt[c][cid] = 1'b0;
          end
        end
      end else if (cid < NIRQ) begin
        spi_nxt[cid-PRIV_COUNT] = 1'b0;
      end
    end
    for (int c = 0; c < CPUS; c++) begin
      bank_nxt[c][15:0] = bank_nxt[c][15:0] | sgi_set_in[16*c +: 16];
      bank_nxt[c][31:16] = bank_nxt[c][31:16] | ppi_lvl[c];
      if (bank_ok && 32'(reg_req_in.cpu) == c) begin
        bank_nxt[c] = bank_nxt[c] | set_bank;
      end
    end
    spi_nxt = spi_nxt | set_spi | spi_lvl;
    ext_nxt = ext_nxt | set_ext | ext_lvl;
  end

  // Forwarding uses the current target list each cycle
  always_comb begin
    logic [CPUS-1:0] t;
    logic are;
    t = '0;
    are = 1'b0;
    fwd_nxt = '0;
    for (int c = 0; c < CPUS; c++) begin
      fwd_nxt[c][PRIV_COUNT-1:0] = bank_r[c];
    end
    for (int i = 0; i < NSPI; i++) begin
      are = are_of(irq_secure_in[i+PRIV_COUNT], route_secure_in, route_nonsecure_in);
      t = FIXED_MASK[i+PRIV_COUNT] ? FIXED_TGT[CPUS-1:0] : tgt_r[i];
      if (CPUS == 1) begin
        t = '1;
      end
      for (int c = 0; c < CPUS; c++) begin
        fwd_nxt[c][i+PRIV_COUNT] = spi_r[i] && t[c] && !are;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      bank_r <= {CPUS{PEND_RST}};
      spi_r <= '0;
      ext_r <= '0;
      tgt_r <= '0;
      rsp_r <= '0;
      fwd_r <= '0;
    end else begin
      bank_r <= bank_nxt;
      spi_r <= spi_nxt;
      ext_r <= ext_nxt;
      tgt_r <= tgt_nxt;
      rsp_r <= rsp_nxt;
      fwd_r <= fwd_nxt;
    end
  end

  assign reg_rsp_out = rsp_r;
  assign cpu_pending_out = fwd_r;
  assign ext_pending_out = ext_r;
endmodule
`default_nettype wire

// ### core/sptr_pkg.sv
`default_nettype none
package sptr_pkg;
  localparam logic [15:0] PEND_BASE = 16'h0200;
  localparam logic [15:0] EXT_BASE = 16'h1600;
  localparam logic [15:0] TGT_BASE = 16'h0800;
  localparam int EXT_ID_BASE = 4096;
  localparam int BITS_PER_REG = 32;
  localparam int BYTES_PER_REG = 4;
  localparam int SGI_COUNT = 16;
  localparam int PRIV_COUNT = 32;
  localparam int MAX_BANK_CPU = 8;
  localparam int SYNC_STAGES = 2;
  localparam logic [31:0] PEND_RST = 32'h0000_0000;
  localparam logic [7:0] TGT_RST = 8'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  typedef struct packed {
    logic valid;
    logic write;
    logic secure;
    logic [3:0] cpu;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } sptr_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } sptr_rsp_type;

  typedef struct packed {
    logic valid;
    logic [3:0] cpu;
    logic [12:0] id;
  } sptr_clr_type;
endpackage
`default_nettype wire

// ### core/sptr_sync.sv
`default_nettype none
module sptr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_in, // Clock
  input wire logic rst_n_in, // Synchronised reset, active low
  input wire logic [WIDTH-1:0] d_in, // Asynchronous levels
  output logic [WIDTH-1:0] q_out // Levels in clock domain
);
  import sptr_pkg::*;

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d_in;
      q_r <= meta_r;
    end
  end

  assign q_out = q_r;
endmodule
`default_nettype wire

// ### testbench/sptr_cpu_model.sv
`default_nettype none
module sptr_cpu_model #(
  parameter int CPUS = 4,
  parameter int NIRQ = 64
) (
  input wire logic sys_clk_in, // Clock
  input wire logic ack_en_in, // Processors may acknowledge
  input wire logic [CPUS-1:0][NIRQ-1:0] pend_in, // Forwarded pending
  output sptr_pkg::sptr_clr_type clr_out, // Acknowledge
  output int acks_out // Acknowledges taken
);
  timeunit 1ns;
  timeprecision 100ps;
  import sptr_pkg::*;
  int gap = 0;
  initial begin
    clr_out = '0;
    acks_out = 0;
  end
  // Hold off while the cleared state ripples out, so one event is taken once
  always @(negedge sys_clk_in) begin
    int pick;
    pick = -1;
    for (int c = CPUS - 1; c >= 0; c--) begin
      if (ack_en_in && gap == 0 && pend_in[c][32]) begin
        pick = c;
      end
    end
    if (pick >= 0) begin
      clr_out <= '{1'b1, 4'(pick), 13'd32};
      acks_out <= acks_out + 1;
      gap <= 4;
    end else begin
      clr_out.valid <= 1'b0;
      gap <= (gap > 0) ? gap - 1 : 0;
    end
  end
endmodule
`default_nettype wire

// ### testbench/sptr_dist_properties.sv
`default_nettype none
module sptr_dist_properties
  import sptr_pkg::*;
#(
  parameter int LINES = 1,
  parameter int CPUS = 4,
  parameter int EXT_SIZE = 0
) (
  input wire logic sys_clk_in, // Clock
  input wire logic rst_n_in, // Reset, active low
  input wire sptr_pkg::sptr_req_type reg_req_in, // Request
  input wire sptr_pkg::sptr_rsp_type reg_rsp_out, // Answer
  input wire logic security_disable_in, // Single security state
  input wire logic route_secure_in, // Routing, secure
  input wire logic route_nonsecure_in, // Routing, non-secure
  input wire logic [32*(EXT_SIZE+1)-1:0] ext_secure_in, // Extended secure
  input wire logic [32*(EXT_SIZE+1)-1:0] ext_line_in, // Extended lines
  input wire logic [CPUS*16-1:0] sgi_set_in, // Software sets
  input wire sptr_pkg::sptr_clr_type clr_in, // Acknowledge
  input wire logic [CPUS-1:0][32*(LINES+1)-1:0] cpu_pending_out, // Forwarded
  input wire logic [32*(EXT_SIZE+1)-1:0] ext_pending_out // Extended pending
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence ext_wr(logic s);
    reg_req_in.valid && reg_req_in.write && reg_req_in.secure == s &&
      reg_req_in.addr == EXT_BASE && reg_req_in.be[0] && reg_req_in.wdata[0];
  endsequence
  sequence line_quiet;
    !ext_line_in[0] [*3];
  endsequence
  a_ack_follows_req: assert property (reg_req_in.valid |=> reg_rsp_out.ack)
    else $error("ack missing");
  a_no_stray_ack: assert property (!reg_req_in.valid |=> !reg_rsp_out.ack)
    else $error("stray ack");
  a_write_reads_zero: assert property (reg_req_in.valid && reg_req_in.write
    |=> reg_rsp_out.rdata == RDATA_RST) else $error("write returned data");
  a_sgi_write_ignored: assert property (reg_req_in.valid && reg_req_in.write &&
    reg_req_in.cpu == 4'h0 && reg_req_in.addr == PEND_BASE && sgi_set_in == '0 &&
    !clr_in.valid |=> ##1 $stable(cpu_pending_out[0][15:0])) else $error("sgi bits written");
  a_ext_secure_set: assert property (ext_wr(1'b1) ##0 route_secure_in &&
    route_nonsecure_in |=> ext_pending_out[0]) else $error("extended set lost");
  a_ext_ns_blocked: assert property (line_quiet ##0 ext_wr(1'b0) ##0
    (!security_disable_in && ext_secure_in[0] && !ext_pending_out[0])
    |=> !ext_pending_out[0]) else $error("non-secure set secure bit");
  a_ext_pend_holds: assert property (ext_pending_out[0] &&
    !(clr_in.valid && clr_in.id == 13'h1000) |=> ext_pending_out[0])
    else $error("pending dropped");
  a_reset_clears: assert property ($rose(rst_n_in) |->
    ext_pending_out == '0 && cpu_pending_out == '0) else $error("pending after reset");
endmodule
bind sptr_dist sptr_dist_properties #(.LINES(LINES), .CPUS(CPUS), .EXT_SIZE(EXT_SIZE)) chk_u (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_req_in(reg_req_in),
  .reg_rsp_out(reg_rsp_out), .security_disable_in(security_disable_in),
  .route_secure_in(route_secure_in), .route_nonsecure_in(route_nonsecure_in),
  .ext_secure_in(ext_secure_in), .ext_line_in(ext_line_in), .sgi_set_in(sgi_set_in),
  .clr_in(clr_in), .cpu_pending_out(cpu_pending_out), .ext_pending_out(ext_pending_out));
`default_nettype wire

// ### testbench/tb_set_pending_and_target_regs.sv
`default_nettype none
module tb_set_pending_and_target_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import sptr_pkg::*;
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ds = 1'b0;
  logic rs = 1'b0;
  logic rns = 1'b0;
  logic ack_en = 1'b0;
  logic [63:0] isec = '1;
  logic [63:0] nsg = '0;
  logic [63:0] ppil = '0;
  logic [63:0] sgi = '0;
  logic [31:0] esec = '1;
  logic [31:0] spil = '0;
  logic [31:0] extl = '0;
  logic [31:0] q;
  logic [31:0] extp;
  logic [3:0][63:0] pend;
  sptr_req_type req = '0;
  sptr_rsp_type rsp;
  sptr_clr_type clr;
  int acks;
  int n_mismatch = 0;
  int num_checks = 0;
  always #2 sys_clk = ~sys_clk;
  sptr_dist dut_u (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .reg_req_in(req),
    .reg_rsp_out(rsp), .security_disable_in(ds), .route_secure_in(rs),
    .route_nonsecure_in(rns), .irq_secure_in(isec), .ns_grant_in(nsg),
    .ext_secure_in(esec), .spi_line_in(spil), .ppi_line_in(ppil), .ext_line_in(extl),
    .sgi_set_in(sgi), .clr_in(clr), .cpu_pending_out(pend), .ext_pending_out(extp));
  sptr_cpu_model cpu_u (.sys_clk_in(sys_clk), .ack_en_in(ack_en), .pend_in(pend),
    .clr_out(clr), .acks_out(acks));
  task automatic final_report;
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, s, input logic [3:0] c, input logic [15:0] a,
                     input logic [31:0] d);
    @(negedge sys_clk);
    req = '{1'b1, w, s, c, a, d, 4'hF};
    @(negedge sys_clk);
    req.valid = 1'b0;
    for (int i = 0; i < 4 && rsp.ack !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (rsp.ack !== 1'b1) begin
      n_mismatch++;
      final_report();
    end
    q = rsp.rdata;
  endtask
  task automatic t_reset_zero;
    logic [15:0] ra [4] = '{16'h0200, 16'h0204, 16'h1600, 16'h0208};
    foreach (ra[i]) begin
      bus(0, 1, 0, ra[i], 0);
      `CHK("reset read", 32'h0, q)
    end
  endtask
  task automatic t_sgi_ppi;
    bus(1, 1, 0, 16'h0200, 32'hFFFF_FFFF);
    bus(0, 1, 0, 16'h0200, 0);
    `CHK("sgi write", 32'hFFFF_0000, q)
    bus(0, 1, 1, 16'h0200, 0);
    `CHK("bank cpu1", 32'h0, q)
    bus(0, 1, 9, 16'h0200, 0);
    `CHK("bank cpu9", 32'h0, q)
    @(negedge sys_clk);
    sgi[0] = 1'b1;
    @(negedge sys_clk);
    sgi[0] = 1'b0;
    bus(0, 1, 0, 16'h0200, 0);
    `CHK("sgi set", 1'b1, q[0])
  endtask
  task automatic t_targets;
    bus(0, 1, 2, 16'h0800, 0);
    `CHK("tgt bank", 32'h0404_0404, q)
    bus(1, 1, 0, 16'h0820, 32'h0000_FF03);
    bus(0, 1, 0, 16'h0820, 0);
    `CHK("tgt rw", 32'h0000_0F03, q)
    bus(1, 1, 0, 16'h0204, 32'h1);
    @(posedge sys_clk);
    #1;
    `CHK("fwd", 4'b0011, {pend[3][32], pend[2][32], pend[1][32], pend[0][32]})
    bus(0, 1, 0, 16'h0204, 0);
    `CHK("pend read", 1'b1, q[0])
    ack_en = 1'b1;
    repeat (10) @(negedge sys_clk);
    ack_en = 1'b0;
    `CHK("acks", 1, acks)
    bus(0, 1, 0, 16'h0204, 0);
    `CHK("acked", 1'b0, q[0])
  endtask
  task automatic t_nonsecure;
    bus(1, 0, 0, 16'h0204, 32'h2);
    bus(0, 1, 0, 16'h0204, 0);
    `CHK("ns blocked", 1'b0, q[1])
    @(negedge sys_clk);
    nsg[33] = 1'b1;
    bus(1, 0, 0, 16'h0204, 32'h2);
    bus(0, 0, 0, 16'h0204, 0);
    `CHK("ns granted", 1'b1, q[1])
    @(negedge sys_clk);
    ds = 1'b1;
    bus(1, 0, 0, 16'h0204, 32'h4);
    bus(0, 0, 0, 16'h0204, 0);
    `CHK("ds open", 1'b1, q[2])
    @(negedge sys_clk);
    ds = 1'b0;
  endtask
  task automatic t_lines;
    @(negedge sys_clk);
    spil[4] = 1'b1;
    ppil[16] = 1'b1;
    extl[1] = 1'b1;
    repeat (3) @(negedge sys_clk);
    spil[4] = 1'b0;
    ppil[16] = 1'b0;
    extl[1] = 1'b0;
    `CHK("ext line", 32'h0000_0002, extp)
    repeat (3) @(negedge sys_clk);
    bus(0, 1, 0, 16'h0204, 0);
    `CHK("spi line", 1'b1, q[4])
    bus(0, 1, 1, 16'h0200, 0);
    `CHK("ppi line", 32'h0001_0000, q)
  endtask
  task automatic t_ext;
    bus(1, 1, 0, 16'h1600, 32'h1);
    bus(0, 1, 0, 16'h1600, 0);
    `CHK("ext unrouted", 32'h0, q)
    @(negedge sys_clk);
    rs = 1'b1;
    rns = 1'b1;
    bus(0, 1, 0, 16'h0200, 0);
    `CHK("routed bank", 32'h0, q)
    bus(0, 1, 0, 16'h0820, 0);
    `CHK("routed tgt", 32'h0, q)
    `CHK("routed fwd", 1'b0, pend[0][33])
    nsg[35] = 1'b1;
    bus(1, 0, 0, 16'h0204, 32'h8);
    bus(0, 1, 0, 16'h0204, 0);
    `CHK("routed ns set", 1'b0, q[3])
    bus(1, 1, 0, 16'h0204, 32'h8);
    bus(0, 1, 0, 16'h0204, 0);
    `CHK("routed s set", 1'b1, q[3])
    bus(1, 0, 0, 16'h1600, 32'h1);
    bus(0, 1, 0, 16'h1600, 0);
    `CHK("ext ns", 32'h2, q)
    bus(1, 1, 0, 16'h1600, 32'h1);
    bus(0, 1, 0, 16'h1600, 0);
    `CHK("ext set", 32'h3, q)
    `CHK("ext out", 32'h3, extp)
  endtask
  task automatic t_mid_reset;
    @(negedge sys_clk);
    rst_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    `CHK("reset out", 32'h0, extp)
    `CHK("reset fwd", 256'h0, pend)
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    bus(0, 1, 0, 16'h0204, 0);
    `CHK("reset spi", 32'h0, q)
    bus(0, 1, 0, 16'h1600, 0);
    `CHK("reset ext", 32'h0, q)
  endtask
  initial begin
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_reset_zero();
    t_sgi_ppi();
    t_targets();
    t_nonsecure();
    t_lines();
    t_ext();
    t_mid_reset();
    final_report();
  end
endmodule
`default_nettype wire
